//--- logic/sdt_reasm_pkg.sv
// Constants and types for the structured reassembly buffer writer
package sdt_reasm_pkg;
    localparam int CH_W = 5;
    localparam int NUM_CH = 32;
    localparam int WP_W = 10;
    localparam int ADDR_W = 20;
    localparam int BASE_W = 12;
    localparam int FRAME_W = 5;
    localparam int LOST_W = 3;

    // Register byte addresses
    localparam logic [15:0] REG_CONTROL = 16'h2040;
    localparam logic [15:0] REG_CONN_CFG = 16'h2050;
    localparam logic [15:0] REG_ENTRY_RANGE = 16'h2052;
    localparam logic [15:0] REG_FILL = 16'h2054;
    localparam logic [15:0] REG_SLIP_POS = 16'h2056;
    localparam logic [15:0] REG_WPTR = 16'h2058;
    localparam logic [15:0] REG_POSITION = 16'h205A;
    localparam logic [15:0] REG_OVF_CNT = 16'h205C;
    localparam logic [15:0] REG_UND_CNT = 16'h205E;
    localparam logic [15:0] REG_BASE_TABLE = 16'h2100;
    localparam logic [15:0] REG_NIBBLE_TABLE = 16'h2180;
    localparam logic [15:0] TABLE_MASK = 16'hFFC1;

    // Field positions
    localparam int CTL_REGION_LSB = 0;
    localparam int CTL_INSERT_ALL = 2;
    localparam int CFG_SIZE_LSB = 0;
    localparam int CFG_SIG_EN = 3;
    localparam int CFG_E1 = 4;
    localparam int RANGE_LAST_LSB = 8;

    // Buffer size select codes
    localparam logic [2:0] SZ_64 = 3'h0;
    localparam logic [2:0] SZ_128 = 3'h1;
    localparam logic [2:0] SZ_256 = 3'h2;
    localparam logic [2:0] SZ_512 = 3'h3;
    localparam logic [2:0] SZ_1024 = 3'h4;

    localparam logic [LOST_W-1:0] DEFAULT_MAX_DUMMY = 3'h2;
    localparam logic [5:0] DUMMY_CELL_BYTES = 6'h2F;
    localparam logic [FRAME_W-1:0] E1_LAST_FRAME = 5'h0F;
    localparam logic [FRAME_W-1:0] DS1_LAST_FRAME = 5'h17;

    typedef struct packed {
        logic multiframe_flag;
        logic reserved;
        logic [1:0] turn;
        logic [3:0] nibble;
        logic [7:0] data;
    } buf_entry_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        buf_entry_t entry;
    } mem_req_t;

    typedef struct packed {
        logic [LOST_W-1:0] lost_cells;
        logic slip;
        logic underrun;
    } cell_hdr_t;
endpackage : sdt_reasm_pkg

//--- logic/structured_reassembly_buffer_writer.sv
// Structured reassembly writer: spreads cell bytes over per-channel circular buffers
`timescale 1ns/10ps

// Functional notes
// - At 64/128 entries buffer base is region bits (two/one) above the 12-bit channel base; larger sizes use no region bits.
// - Each entry is flag, reserved, turn, nibble, data byte.
// - Multiframe flag marks each channel at multiframe start; zero without signalling.
// - Reserved entry bit is always written as zero.
// - Turn field is the two top bits of the write pointer.
// - Nibble field repeats the channel's last received signalling nibble.
// - Data byte is received byte, or fill value for dummy cells.
// - On cell loss write dummy cells first, then the received cell.
// - At most two dummy cells unless insert-all is set.
// - Each dummy cell is exactly 47 fill bytes.
// - Channel index steps first to last per byte, then wraps.
// - A pointer reframe forces the channel index to the first entry.
// - With signalling, frame counter increments on each channel index wrap.
// - Last frame of a multiframe carries signalling nibbles, not payload.
// - Frame counter returns to zero after the last frame or on reframe.
// - Write address joins channel base with the shared write pointer.
// - Shared write pointer increments on each channel index wrap, except at the wrap that ends the last (signalling) frame.
// - Size select picks 64 to 1024 entries for all buffers.
// - On a slip, pointer jumps to slip position and counter increments.
module structured_reassembly_buffer_writer
    import sdt_reasm_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire logic i_hdr_valid,
    input cell_hdr_t i_hdr,
    output logic o_hdr_ready,
    input wire logic i_byte_valid,
    input wire logic [7:0] i_byte,
    input wire logic i_byte_last,
    output logic o_byte_ready,
    input wire logic i_reframe,
    output logic o_mem_valid,
    output mem_req_t o_mem,
    input wire logic i_mem_ready
);

    typedef enum logic [1:0] {ST_IDLE, ST_DUMMY, ST_DATA} state_t;

    state_t state;
    logic [1:0] global_region_bits;
    logic insert_all_lost_cells;
    logic [2:0] buffer_size_select;
    logic sig_en;
    logic e1_mode;
    logic [CH_W-1:0] first_entry;
    logic [CH_W-1:0] last_entry;
    logic [7:0] fill_byte;
    logic [WP_W-1:0] slip_pos;
    logic [15:0] ovf_cnt;
    logic [15:0] und_cnt;
    logic [BASE_W-1:0] base_table [NUM_CH];
    logic [3:0] nibble_table [NUM_CH];

    logic [CH_W-1:0] cur_entry;
    logic [FRAME_W-1:0] cur_frame;
    logic [WP_W-1:0] wptr;
    logic start_armed;
    logic [LOST_W-1:0] cells_left;
    logic [5:0] bytes_left;

    logic step_ok;
    logic hdr_take;
    logic byte_take;
    logic dummy_step;
    logic step;
    logic wrap;
    logic cas_frame;
    logic [FRAME_W-1:0] last_frame;
    logic [7:0] step_byte;
    logic [LOST_W-1:0] insert_count;
    logic [CH_W-1:0] tbl_idx;
    logic tbl_base_hit;
    logic tbl_nib_hit;

    // Address of the entry at the given pointer for the current size
    function automatic logic [ADDR_W-1:0] entry_addr(
        input logic [2:0] sz,
        input logic [1:0] region,
        input logic [BASE_W-1:0] base,
        input logic [WP_W-1:0] wp
    );
        unique case (sz)
            SZ_128: return {region[0], base, wp[6:0]};
            SZ_256: return {base, wp[7:0]};
            SZ_512: return {base[10:0], wp[8:0]};
            SZ_1024: return {base[9:0], wp[9:0]};
            default: return {region, base, wp[5:0]};
        endcase
    endfunction : entry_addr

    // Top two pointer bits at the current size
    function automatic logic [1:0] turn_of(input logic [2:0] sz, input logic [WP_W-1:0] wp);
        unique case (sz)
            SZ_128: return wp[6:5];
            SZ_256: return wp[7:6];
            SZ_512: return wp[8:7];
            SZ_1024: return wp[9:8];
            default: return wp[5:4];
        endcase
    endfunction : turn_of

    // Pointer wrap mask at the current size
    function automatic logic [WP_W-1:0] wp_mask(input logic [2:0] sz);
        unique case (sz)
            SZ_128: return 10'h07F;
            SZ_256: return 10'h0FF;
            SZ_512: return 10'h1FF;
            SZ_1024: return 10'h3FF;
            default: return 10'h03F;
        endcase
    endfunction : wp_mask

    assign step_ok = !o_mem_valid || i_mem_ready;
    assign o_hdr_ready = (state == ST_IDLE);
    assign o_byte_ready = (state == ST_DATA) && step_ok;
    assign hdr_take = i_hdr_valid && o_hdr_ready;
    assign byte_take = i_byte_valid && o_byte_ready;
    assign dummy_step = (state == ST_DUMMY) && step_ok;
    assign step = byte_take || dummy_step;
    assign step_byte = dummy_step ? fill_byte : i_byte;
    assign wrap = (cur_entry == last_entry);
    assign last_frame = e1_mode ? E1_LAST_FRAME : DS1_LAST_FRAME;
    assign cas_frame = sig_en && (cur_frame == last_frame);
    assign tbl_idx = i_addr[CH_W:1];
    assign tbl_base_hit = (i_addr & TABLE_MASK) == REG_BASE_TABLE;
    assign tbl_nib_hit = (i_addr & TABLE_MASK) == REG_NIBBLE_TABLE;

    assign insert_count = (!insert_all_lost_cells && (i_hdr.lost_cells > DEFAULT_MAX_DUMMY)) ?
                          DEFAULT_MAX_DUMMY : i_hdr.lost_cells;

    // Software-written configuration
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            global_region_bits <= '0;
            insert_all_lost_cells <= 1'b0;
            buffer_size_select <= SZ_64;
            sig_en <= 1'b0;
            e1_mode <= 1'b0;
            first_entry <= '0;
            last_entry <= '0;
            fill_byte <= '0;
            slip_pos <= '0;
        end
        else if (i_wr)
        begin
            unique case (i_addr)
                REG_CONTROL:
                begin
                    global_region_bits <= i_wdata[CTL_REGION_LSB +: 2];
                    insert_all_lost_cells <= i_wdata[CTL_INSERT_ALL];
                end
                REG_CONN_CFG:
                begin
                    buffer_size_select <= i_wdata[CFG_SIZE_LSB +: 3];
                    sig_en <= i_wdata[CFG_SIG_EN];
                    e1_mode <= i_wdata[CFG_E1];
                end
                REG_ENTRY_RANGE:
                begin
                    first_entry <= i_wdata[CH_W-1:0];
                    last_entry <= i_wdata[RANGE_LAST_LSB +: CH_W];
                end
                REG_FILL: fill_byte <= i_wdata[7:0];
                REG_SLIP_POS: slip_pos <= i_wdata[WP_W-1:0];
                default: ;
            endcase
        end
    end

    // Per-channel base and signalling nibble tables
    generate
        for (genvar g = 0; g < NUM_CH; g++)
        begin : g_chan
            always_ff @(posedge i_clk)
            begin
                if (!i_rst_n)
                begin
                    base_table[g] <= '0;
                    nibble_table[g] <= '0;
                end
                else
                begin
                    if (i_wr && tbl_base_hit && (tbl_idx == CH_W'(g)))
                    begin
                        base_table[g] <= i_wdata[BASE_W-1:0];
                    end
                    if (byte_take && cas_frame && (cur_entry == CH_W'(g)))
                    begin
                        nibble_table[g] <= i_byte[3:0];
                    end
                    else if (i_wr && tbl_nib_hit && (tbl_idx == CH_W'(g)))
                    begin
                        nibble_table[g] <= i_wdata[3:0];
                    end
                end
            end
        end
    endgenerate

    // Cell sequencing: dummy cells before the received cell
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            state <= ST_IDLE;
            cells_left <= '0;
            bytes_left <= '0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    if (hdr_take)
                    begin
                        cells_left <= insert_count;
                        bytes_left <= DUMMY_CELL_BYTES;
                        state <= (insert_count != '0) ? ST_DUMMY : ST_DATA;
                    end
                end
                ST_DUMMY:
                begin
                    if (dummy_step)
                    begin
                        if (bytes_left == 6'h01)
                        begin
                            bytes_left <= DUMMY_CELL_BYTES;
                            cells_left <= cells_left - 1'b1;
                            if (cells_left == 3'h1)
                            begin
                                state <= ST_DATA;
                            end
                        end
                        else
                        begin
                            bytes_left <= bytes_left - 1'b1;
                        end
                    end
                end
                ST_DATA:
                begin
                    if (byte_take && i_byte_last)
                    begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Channel index and frame progression
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            cur_entry <= '0;
            cur_frame <= '0;
            start_armed <= 1'b0;
        end
        else if (i_reframe)
        begin
            cur_entry <= first_entry;
            cur_frame <= '0;
            start_armed <= 1'b0;
        end
        else if (step)
        begin
            cur_entry <= wrap ? first_entry : cur_entry + 1'b1;
            if (wrap && sig_en)
            begin
                if (cas_frame)
                begin
                    cur_frame <= '0;
                    start_armed <= 1'b1;
                end
                else
                begin
                    cur_frame <= cur_frame + 1'b1;
                    start_armed <= 1'b0;
                end
            end
        end
    end

    // Shared write pointer and slip handling
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            wptr <= '0;
            ovf_cnt <= '0;
            und_cnt <= '0;
        end
        else if (hdr_take && i_hdr.slip)
        begin
            wptr <= slip_pos & wp_mask(buffer_size_select);
            if (i_hdr.underrun)
            begin
                und_cnt <= und_cnt + 1'b1;
            end
            else
            begin
                ovf_cnt <= ovf_cnt + 1'b1;
            end
        end
        else if (step && wrap && !cas_frame)
        begin
            wptr <= (wptr + 1'b1) & wp_mask(buffer_size_select);
        end
    end

    // External memory write request
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_mem_valid <= 1'b0;
            o_mem <= '0;
        end
        else if (step && !cas_frame)
        begin
            o_mem_valid <= 1'b1;
            o_mem.addr <= entry_addr(buffer_size_select, global_region_bits,
                                     base_table[cur_entry], wptr);
            o_mem.entry.multiframe_flag <= sig_en && start_armed;
            o_mem.entry.reserved <= 1'b0;
            o_mem.entry.turn <= turn_of(buffer_size_select, wptr);
            o_mem.entry.nibble <= nibble_table[cur_entry];
            o_mem.entry.data <= step_byte;
        end
        else if (i_mem_ready)
        begin
            o_mem_valid <= 1'b0;
        end
    end

    // Register read port, data valid one cycle after the strobe
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_rdata <= '0;
        end
        else if (i_rd)
        begin
            if (tbl_base_hit)
            begin
                o_rdata <= 16'(base_table[tbl_idx]);
            end
            else if (tbl_nib_hit)
            begin
                o_rdata <= 16'(nibble_table[tbl_idx]);
            end
            else
            begin
                unique case (i_addr)
                    REG_CONTROL: o_rdata <= {13'h0000, insert_all_lost_cells, global_region_bits};
                    REG_CONN_CFG: o_rdata <= {11'h000, e1_mode, sig_en, buffer_size_select};
                    REG_ENTRY_RANGE: o_rdata <= {3'h0, last_entry, 3'h0, first_entry};
                    REG_FILL: o_rdata <= {8'h00, fill_byte};
                    REG_SLIP_POS: o_rdata <= 16'(slip_pos);
                    REG_WPTR: o_rdata <= 16'(wptr);
                    REG_POSITION: o_rdata <= {3'h0, cur_frame, 3'h0, cur_entry};
                    REG_OVF_CNT: o_rdata <= ovf_cnt;
                    REG_UND_CNT: o_rdata <= und_cnt;
                    default: o_rdata <= '0;
                endcase
            end
        end
        else
        begin
            o_rdata <= '0;
        end
    end

endmodule : structured_reassembly_buffer_writer

//--- testbench/sdt_writer_checker.sv
// Port-level assertions for the structured reassembly writer
`timescale 1ns/10ps
module sdt_writer_checker
    import sdt_reasm_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_hdr_valid,
    input wire cell_hdr_t i_hdr,
    input wire logic o_hdr_ready,
    input wire logic i_byte_valid,
    input wire logic [7:0] i_byte,
    input wire logic o_byte_ready,
    input wire logic o_mem_valid,
    input wire mem_req_t o_mem,
    input wire logic i_mem_ready
);
    logic [1:0] region;
    logic [2:0] size;
    logic sig_en;
    logic [4:0] wp_msb;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    // Shadow of the configuration that shapes each entry
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            region <= 2'h0;
            size <= 3'h0;
            sig_en <= 1'b0;
        end
        else if (i_wr && i_addr == REG_CONTROL)
            region <= i_wdata[1:0];
        else if (i_wr && i_addr == REG_CONN_CFG)
        begin
            size <= (i_wdata[2:0] > 3'h4) ? 3'h0 : i_wdata[2:0];
            sig_en <= i_wdata[CFG_SIG_EN];
        end
    end
    assign wp_msb = 5'h5 + {2'h0, size};
    sequence s_hdr_take;
        i_hdr_valid && o_hdr_ready;
    endsequence
    sequence s_byte_take;
        i_byte_valid && o_byte_ready;
    endsequence
    a_reserved_zero: assert property (o_mem_valid |-> !o_mem.entry.reserved)
        else $error("reserved bit set");
    a_mem_hold: assert property (o_mem_valid && !i_mem_ready |=> o_mem_valid && $stable(o_mem))
        else $error("write request dropped or changed");
    a_turn_bits: assert property (o_mem_valid |-> o_mem.entry.turn == o_mem.addr[wp_msb -: 2])
        else $error("turn differs from pointer top bits");
    a_region_bits: assert property (o_mem_valid && size < 3'h2 |->
        (size == 3'h0 ? o_mem.addr[19:18] == region : o_mem.addr[19] == region[0]))
        else $error("region bits wrong");
    a_mf_clear: assert property (o_mem_valid && !sig_en |-> !o_mem.entry.multiframe_flag)
        else $error("multiframe flag without signalling");
    a_byte_data: assert property (s_byte_take ##0 !sig_en |=> o_mem_valid && o_mem.entry.data == $past(i_byte))
        else $error("byte not written next cycle");
    a_dummy_first: assert property (s_hdr_take ##0 i_hdr.lost_cells != 3'h0 |=> !o_byte_ready [*8])
        else $error("bytes taken before dummy fill");
    a_no_dummy: assert property (s_hdr_take ##0 (i_hdr.lost_cells == 3'h0 && !o_mem_valid) |=> o_byte_ready)
        else $error("data phase late without loss");
    a_hdr_busy: assert property (s_hdr_take |=> !o_hdr_ready)
        else $error("header ready during a cell");
endmodule : sdt_writer_checker

//--- testbench/buffer_memory_model.sv
// External buffer memory that stalls writes at random
`timescale 1ns/10ps
module buffer_memory_model
    import sdt_reasm_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_stall_en,
    input wire logic i_mem_valid,
    input wire mem_req_t i_mem,
    output logic o_mem_ready
);
    buf_entry_t store [int];
    always @(posedge i_clk)
    begin
        if (i_rst_n && i_mem_valid && o_mem_ready)
            store[int'(i_mem.addr)] = i_mem.entry;
        if (!i_rst_n)
            o_mem_ready <= 1'b0;
        else
            o_mem_ready <= !i_stall_en || ($urandom % 3 != 0);
    end
endmodule : buffer_memory_model

//--- testbench/tb_structured_reassembly_buffer_writer.sv
// Self-checking bench for the structured reassembly writer
`timescale 1ns/10ps
module tb_structured_reassembly_buffer_writer
    import sdt_reasm_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [15:0] i_addr = 16'h0;
    logic [15:0] i_wdata = 16'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [15:0] o_rdata;
    logic i_hdr_valid = 1'b0;
    cell_hdr_t i_hdr = '0;
    logic o_hdr_ready;
    logic i_byte_valid = 1'b0;
    logic [7:0] i_byte = 8'h0;
    logic i_byte_last = 1'b0;
    logic o_byte_ready;
    logic i_reframe = 1'b0;
    logic o_mem_valid;
    mem_req_t o_mem;
    logic i_mem_ready;
    logic stall_en = 1'b0;
    int err_total = 0;
    int tests_run = 0;
    mem_req_t exp_q [$];
    mem_req_t last_wr;
    // Reference state
    logic [1:0] region = 2'h0;
    logic [2:0] sz = 3'h0;
    logic insert_all = 1'b0, sig_en = 1'b0, e1 = 1'b0, start = 1'b0;
    logic [4:0] first = 5'h0, last = 5'h0, ch = 5'h0, frame = 5'h0;
    logic [7:0] fill = 8'h0;
    logic [9:0] slip_pos = 10'h0, wp = 10'h0;
    logic [15:0] ovf = 16'h0, und = 16'h0;
    logic [11:0] base [NUM_CH];
    logic [3:0] nib [NUM_CH];

    always #2.5 i_clk = ~i_clk;

    structured_reassembly_buffer_writer structured_reassembly_buffer_writer_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_hdr_valid(i_hdr_valid), .i_hdr(i_hdr), .o_hdr_ready(o_hdr_ready), .i_byte_valid(i_byte_valid),
        .i_byte(i_byte), .i_byte_last(i_byte_last), .o_byte_ready(o_byte_ready), .i_reframe(i_reframe),
        .o_mem_valid(o_mem_valid), .o_mem(o_mem), .i_mem_ready(i_mem_ready));
    buffer_memory_model buffer_memory_model_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_stall_en(stall_en),
        .i_mem_valid(o_mem_valid), .i_mem(o_mem), .o_mem_ready(i_mem_ready));

    task automatic check(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1)
        begin
            err_total++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask : check

    task automatic end_sim();
        if (err_total == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    function automatic logic [9:0] wmask();
        return 10'((11'h40 << sz) - 11'h1);
    endfunction : wmask

    function automatic logic [19:0] addr_of(input logic [11:0] b);
        case (sz)
            SZ_128: return {region[0], b, wp[6:0]};
            SZ_256: return {b, wp[7:0]};
            SZ_512: return {b[10:0], wp[8:0]};
            SZ_1024: return {b[9:0], wp};
            default: return {region, b, wp[5:0]};
        endcase
    endfunction : addr_of

    function automatic logic sig_frame();
        return sig_en && frame == (e1 ? E1_LAST_FRAME : DS1_LAST_FRAME);
    endfunction : sig_frame

    // One byte through the channel, frame and pointer progression
    task automatic step(input logic [7:0] d, input logic dum = 1'b0);
        logic sf;
        mem_req_t r;
        sf = sig_frame();
        if (sf)
            nib[ch] = dum ? nib[ch] : d[3:0];
        else
        begin
            r.addr = addr_of(base[ch]);
            r.entry = {sig_en && start && frame == 5'h0, 1'b0, wp[5 + sz -: 2], nib[ch], d};
            exp_q.push_back(r);
        end
        if (ch != last)
            ch = ch + 5'h1;
        else
        begin
            ch = first;
            if (!sf)
                wp = (wp + 10'h1) & wmask();
            if (sig_en)
            begin
                start = sf;
                frame = sf ? 5'h0 : frame + 5'h1;
            end
        end
    endtask : step

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        check(o_rdata === e, "register read");
        @(posedge i_clk);
    endtask : rd

    task automatic reframe();
        i_reframe <= 1'b1;
        @(posedge i_clk);
        i_reframe <= 1'b0;
        @(posedge i_clk);
        ch = first;
        frame = 5'h0;
        start = 1'b0;
    endtask : reframe

    task automatic set_mode(input logic [2:0] s, input logic sg, input logic e);
        sz = s;
        sig_en = sg;
        e1 = e;
        wr(REG_CONN_CFG, {11'h0, e, sg, s});
        reframe();
    endtask : set_mode

    task automatic drain();
        int n;
        n = 0;
        do @(negedge i_clk); while ((exp_q.size() != 0 || o_mem_valid !== 1'b0) && ++n < 3000);
        check(n < 3000, "memory writes missing");
        @(posedge i_clk);
    endtask : drain

    task automatic send_cell(input logic [2:0] lost, input logic slip, input logic under, input int nb);
        int n;
        int k;
        logic [7:0] d;
        drain();
        i_hdr_valid <= 1'b1;
        i_hdr <= '{lost, slip, under};
        n = 0;
        do @(negedge i_clk); while (o_hdr_ready !== 1'b1 && ++n < 500);
        check(n < 500, "header refused");
        @(posedge i_clk);
        i_hdr_valid <= 1'b0;
        if (slip)
        begin
            wp = slip_pos & wmask();
            if (under)
                und++;
            else
                ovf++;
        end
        k = insert_all ? lost : (lost > 3'h2 ? 2 : lost);
        repeat (k * 47) step(fill, 1'b1);
        for (int i = 0; i < nb; i++)
        begin
            d = 8'($urandom);
            if (sig_frame())
                d = {2{d[3:0]}};
            step(d);
            i_byte_valid <= 1'b1;
            i_byte <= d;
            i_byte_last <= (i == nb - 1);
            n = 0;
            do @(negedge i_clk); while (o_byte_ready !== 1'b1 && ++n < 500);
            check(n < 500, "byte refused");
            @(posedge i_clk);
        end
        i_byte_valid <= 1'b0;
        i_byte_last <= 1'b0;
        drain();
    endtask : send_cell

    // Oldest expected write against each accepted one
    always @(posedge i_clk)
        if (i_rst_n && o_mem_valid && i_mem_ready)
        begin
            if (exp_q.size() == 0)
                check(1'b0, "unexpected memory write");
            else
            begin
                last_wr = exp_q.pop_front();
                check(o_mem === last_wr, "memory write mismatch");
            end
        end

    initial
    begin
        repeat (60000) @(posedge i_clk);
        err_total++;
        end_sim();
    end

    initial
    begin
        void'($urandom(22365));
        repeat (20) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        check(o_hdr_ready === 1'b1 && o_byte_ready === 1'b0 && o_mem_valid === 1'b0, "reset outputs");
        rd(REG_CONTROL, 16'h0);
        rd(REG_WPTR, 16'h0);
        wr(16'h3000, 16'hFFFF);
        rd(16'h3000, 16'h0);
        region = 2'h2;
        wr(REG_CONTROL, {14'h0, region});
        first = 5'h1;
        last = 5'h3;
        wr(REG_ENTRY_RANGE, {3'h0, last, 3'h0, first});
        for (int i = 0; i < NUM_CH; i++)
        begin
            base[i] = 12'h0A0 + 12'(i);
            nib[i] = 4'($urandom);
            wr(REG_BASE_TABLE + 16'(2 * i), {4'h0, base[i]});
            wr(REG_NIBBLE_TABLE + 16'(2 * i), {12'h0, nib[i]});
        end
        fill = 8'($urandom);
        wr(REG_FILL, {8'h0, fill});
        slip_pos = 10'h2 + 10'(2 * ($urandom % 64));
        wr(REG_SLIP_POS, {6'h0, slip_pos});
        stall_en <= 1'b1;
        for (int s = 0; s < 5; s++)
        begin
            set_mode(3'(s), 1'b0, 1'b0);
            send_cell(3'h0, 1'b1, s[0], 40);
            send_cell(3'(s), 1'b0, 1'b0, 20);
            rd(REG_WPTR, {6'h0, wp});
            rd(REG_POSITION, {3'h0, frame, 3'h0, ch});
        end
        insert_all = 1'b1;
        wr(REG_CONTROL, {13'h0, 1'b1, region});
        send_cell(3'h5, 1'b1, 1'b1, 10);
        rd(REG_WPTR, {6'h0, wp});
        first = 5'h0;
        last = 5'h2;
        wr(REG_ENTRY_RANGE, {3'h0, last, 3'h0, first});
        for (int e = 0; e < 2; e++)
        begin
            set_mode(SZ_256, 1'b1, e[0]);
            send_cell(3'(e), 1'b0, 1'b0, e ? 52 : 76);
            rd(REG_POSITION, {3'h0, frame, 3'h0, ch});
        end
        reframe();
        rd(REG_POSITION, {3'h0, frame, 3'h0, ch});
        rd(REG_OVF_CNT, ovf);
        rd(REG_UND_CNT, und);
        check(buffer_memory_model_i.store[int'(last_wr.addr)] === last_wr.entry, "buffer content");
        end_sim();
    end
endmodule : tb_structured_reassembly_buffer_writer

bind structured_reassembly_buffer_writer sdt_writer_checker sdt_writer_checker_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_hdr_valid(i_hdr_valid), .i_hdr(i_hdr),
    .o_hdr_ready(o_hdr_ready), .i_byte_valid(i_byte_valid), .i_byte(i_byte), .o_byte_ready(o_byte_ready),
    .o_mem_valid(o_mem_valid), .o_mem(o_mem), .i_mem_ready(i_mem_ready));
